// >>> rtl/event_router_pkg.sv
// event router package: sizes, generator codes, reset values
// assumes a single peripheral clock domain for the router logic
`default_nettype none

package event_router_pkg;

  // ==========================================================
  // sizes
  localparam int NUM_CHANNELS = 6;
  localparam int NUM_GENS     = 32;
  localparam int NUM_USERS    = 16;
  localparam int GEN_SEL_W    = 6;
  localparam int USER_SEL_W   = 3;

  // ==========================================================
  // generator selection codes (0 = none)
  localparam logic [GEN_SEL_W-1:0] GEN_NONE  = 6'h00;
  localparam logic [GEN_SEL_W-1:0] GEN_FIRST = 6'h01;

  // user selection: 0 = off, n = channel n-1
  localparam logic [USER_SEL_W-1:0] USER_OFF = 3'h0;

  // ==========================================================
  // reset values
  localparam logic [GEN_SEL_W-1:0]  GEN_SEL_RESET  = GEN_NONE;
  localparam logic [USER_SEL_W-1:0] USER_SEL_RESET = USER_OFF;

  // synchroniser depth for async sources
  localparam int SYNC_STAGES = 2;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [NUM_CHANNELS-1:0] async_sub;
    logic [NUM_CHANNELS-1:0] sync_sub;
  } channel_bus_t;

  typedef struct packed {
    logic                   we;
    logic [2:0]             index;
    logic [GEN_SEL_W-1:0]   value;
  } gen_write_t;

  typedef struct packed {
    logic                   we;
    logic [3:0]             index;
    logic [USER_SEL_W-1:0]  value;
  } user_write_t;

endpackage

`default_nettype wire

// >>> rtl/event_router.sv
// event router: generator muxes per channel, channel muxes per user
// assumes generator inputs are grouped, codes 1..32 map to gen_in[0..31],
// and gen_is_async marks inputs not generated on clk
//
// Summary of operation
// - each user has its own channel mux
// - software write sets user channel select
// - one generator drives each channel at once
// - software write sets channel generator select
// - channels start unconnected after reset
// - async events pass after one clk edge, through the output register
// - sync pulses last one clock cycle
// - async pulses last one foreign clock cycle
// - sync levels may last many cycles
// - async levels from clockless or foreign sources
// - periodic ticks are real-time domain levels
// - timer type A pulses last one cycle
// - baud and host clocks last two cycles
// - debug sync character seen is a level
// - pins, logic, comparators, zero-cross follow level
// - each channel has async and sync subchannels
// - async sources synchronised, two-three cycles delay
// - software event inverts channel one cycle
`timescale 1ns/1ps
`default_nettype none

module event_router
  import event_router_pkg::*;
(
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     nrst,
  // generator events, classed per input
  input  wire logic [NUM_GENS-1:0]      gen_in,
  input  wire logic [NUM_GENS-1:0]      gen_is_async,
  // configuration writes and software events
  input  wire gen_write_t               gen_write,
  input  wire user_write_t              user_write,
  input  wire logic [NUM_CHANNELS-1:0]  software_event_trigger,
  // channel subchannels
  output logic [NUM_CHANNELS-1:0]       channel_async,
  output logic [NUM_CHANNELS-1:0]       channel_sync,
  // per-user selected event
  output logic [NUM_USERS-1:0]          user_async_event,
  output logic [NUM_USERS-1:0]          user_sync_event
);

  // ==========================================================
  // reset release
  logic [1:0] rst_pipe;
  wire logic  rst_n = rst_pipe[1];

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rst_pipe <= 2'h0;
    else
      rst_pipe <= {rst_pipe[0], 1'b1};
  end

  // ==========================================================
  // state
  typedef struct packed {
    logic [NUM_CHANNELS-1:0][GEN_SEL_W-1:0]  channel_generator_select;
    logic [NUM_USERS-1:0][USER_SEL_W-1:0]    user_channel_select;
    logic [NUM_CHANNELS-1:0]                 sync_s1;
    logic [NUM_CHANNELS-1:0]                 sync_s2;
    logic [NUM_CHANNELS-1:0]                 sw_pulse;
    channel_bus_t                            out_ch;
    logic [NUM_USERS-1:0]                    out_ua;
    logic [NUM_USERS-1:0]                    out_us;
  } state_t;

  state_t st;
  state_t next_st;

  // pick generator for a selection code; none or unknown reads low
  function automatic logic pick_gen(input logic [GEN_SEL_W-1:0] sel,
                                    input logic [NUM_GENS-1:0] vec);
    logic [GEN_SEL_W-1:0] idx;
    idx = sel - GEN_FIRST;
    if (sel == GEN_NONE || idx >= GEN_SEL_W'(NUM_GENS))
      pick_gen = 1'b0;
    else
      pick_gen = vec[idx[4:0]];
  endfunction

  // pick channel for a user selection code
  function automatic logic pick_ch(input logic [USER_SEL_W-1:0] sel,
                                   input logic [NUM_CHANNELS-1:0] vec);
    logic [USER_SEL_W-1:0] idx;
    idx = sel - 3'h1;
    if (sel == USER_OFF || idx >= USER_SEL_W'(NUM_CHANNELS))
      pick_ch = 1'b0;
    else
      pick_ch = vec[idx];
  endfunction

  // ==========================================================
  // combinational raw channel values
  logic [NUM_CHANNELS-1:0] raw;
  logic [NUM_CHANNELS-1:0] raw_async;
  logic [NUM_CHANNELS-1:0] sync_path;
  logic [NUM_CHANNELS-1:0] async_path;

  genvar c;
  generate
    for (c = 0; c < NUM_CHANNELS; c++)
    begin : g_chan
      // sync, async, pulse and level sources share the same mux
      assign raw[c]       = pick_gen(st.channel_generator_select[c], gen_in);
      assign raw_async[c] = pick_gen(st.channel_generator_select[c], gen_is_async);
      // sync subchannel: synchronised copy for async sources
      assign sync_path[c] = (raw_async[c] ? st.sync_s2[c] : raw[c]) ^ st.sw_pulse[c];
      assign async_path[c] = raw[c] ^ st.sw_pulse[c];
    end
  endgenerate

  // ==========================================================
  // next state
  always_comb
  begin
    next_st = st;
    if (gen_write.we && gen_write.index < 3'(NUM_CHANNELS))
      next_st.channel_generator_select[gen_write.index] = gen_write.value;
    if (user_write.we)
      next_st.user_channel_select[user_write.index] = user_write.value;
    // async sources, including periodic ticks, debug sync, pins, logic,
    // comparators and zero-cross, enter via the two-stage synchroniser
    next_st.sync_s1  = raw;
    next_st.sync_s2  = st.sync_s1;
    next_st.sw_pulse = software_event_trigger;
    next_st.out_ch.async_sub = async_path;
    next_st.out_ch.sync_sub  = sync_path;
    for (int u = 0; u < NUM_USERS; u++)
    begin
      next_st.out_ua[u] = pick_ch(st.user_channel_select[u], async_path);
      next_st.out_us[u] = pick_ch(st.user_channel_select[u], sync_path);
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= '0;
      for (int i = 0; i < NUM_CHANNELS; i++)
        st.channel_generator_select[i] <= GEN_SEL_RESET;
      for (int j = 0; j < NUM_USERS; j++)
        st.user_channel_select[j] <= USER_SEL_RESET;
    end
    else
      st <= next_st;
  end

  // ==========================================================
  // outputs straight from registers
  assign channel_async    = st.out_ch.async_sub;
  assign channel_sync     = st.out_ch.sync_sub;
  assign user_async_event = st.out_ua;
  assign user_sync_event  = st.out_us;

endmodule // event_router

`default_nettype wire

// >>> sim/event_router_monitor.sv
// checker on router ports: channel 0 and user 0
// assumes nrst low resets, writes taken on clk rise
`timescale 1ns/1ps
`default_nettype none
module event_router_monitor
  import event_router_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [31:0] gen_in,
  input wire logic [31:0] gen_is_async,
  input wire gen_write_t gen_write,
  input wire user_write_t user_write,
  input wire logic [5:0] software_event_trigger,
  input wire logic [5:0] channel_async,
  input wire logic [5:0] channel_sync,
  input wire logic [15:0] user_async_event,
  input wire logic [15:0] user_sync_event
);
  // ==== shadow selects
  logic [5:0] g;
  logic [2:0] u;
  wire logic [4:0] i = 5'(g - 6'h01);
  wire logic [2:0] c = u - 3'h1;
  wire logic gv = g != 6'h00 && g < 6'h21;
  wire logic uv = u != 3'h0 && u != 3'h7;
  wire logic s = software_event_trigger[0];
  wire logic a = channel_async[0];
  wire logic y = channel_sync[0];
  always_ff @(posedge clk or negedge nrst)
    if (!nrst) {g, u} <= 9'h000;
    else {g, u} <= {gen_write.we && gen_write.index == 3'h0 ? gen_write.value : g,
      user_write.we && user_write.index == 4'h0 ? user_write.value : u};
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_rst; $rose(nrst) |-> (channel_sync == 6'h00 && user_sync_event == 16'h0000) [*2]; endproperty
  a_rst: assert property (p_rst) else $error("reset out");
  // software trigger is registered once before the output register
  property p_idle; g == 6'h00 && $stable(g) |-> a == $past(s, 2) && y == $past(s, 2); endproperty
  a_idle: assert property (p_idle) else $error("idle out");
  property p_sync; gv && $stable(g) && !gen_is_async[i] |-> y == ($past(gen_in[i]) ^ $past(s, 2)); endproperty
  a_sync: assert property (p_sync) else $error("sync route");
  property p_async; gv && $stable(g) |-> a == ($past(gen_in[i]) ^ $past(s, 2)); endproperty
  a_async: assert property (p_async) else $error("async route");
  property p_dly; $stable(g) [*4] ##0 gv && gen_is_async[i] |-> y == ($past(gen_in[i], 3) ^ $past(s, 2)); endproperty
  a_dly: assert property (p_dly) else $error("sync delay");
  // user and channel outputs register the same combinational value
  property p_us; uv && $stable(u) |-> user_sync_event[0] == channel_sync[c]; endproperty
  a_us: assert property (p_us) else $error("user sync");
  property p_ua; uv && $stable(u) |-> user_async_event[0] == channel_async[c]; endproperty
  a_ua: assert property (p_ua) else $error("user async");
  property p_off; !uv && $stable(u) |-> !user_sync_event[0] && !user_async_event[0]; endproperty
  a_off: assert property (p_off) else $error("user off");
  c_p: cover property (gv && y);
  c_s: cover property (s);
  c_u: cover property (user_sync_event[0]);
endmodule // event_router_monitor
bind event_router event_router_monitor mon_u (.*);
`default_nettype wire

// >>> sim/gen_model.sv
// generator side: sync pulse on code 1, async pin level on code 32
// assumes fire and pin move at the clk falling edge
`timescale 1ns/1ps
`default_nettype none
module gen_model
(
  input wire logic clk,
  input wire logic fire,
  input wire logic pin,
  output logic [31:0] gen_in,
  output logic [31:0] gen_is_async
);
  logic p = 1'b0;
  logic q = 1'b0;
  assign gen_in = {q, 30'h0, p};
  assign gen_is_async = 32'h80000000;
  always_ff @(posedge clk) p <= fire & ~p;
  always @(pin) q <= #1.3 pin;
endmodule // gen_model
`default_nettype wire

// >>> sim/tb_top.sv
// bench: router fed by gen_model, channel 0, users 0 and 1
// assumes 200 MHz clk, inputs move at the falling edge
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import event_router_pkg::*;
;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic fire = 1'b0;
  logic pin = 1'b0;
  logic [31:0] gi;
  logic [31:0] ga;
  gen_write_t gw = '0;
  user_write_t uw = '0;
  logic [5:0] sw = '0;
  logic [5:0] ca;
  logic [5:0] cs;
  logic [15:0] ua;
  logic [15:0] us;
  int fail_count = 0;
  int cmp_count = 0;
  always #2.5 clk = ~clk;
  gen_model gen_u (.clk(clk), .fire(fire), .pin(pin), .gen_in(gi), .gen_is_async(ga));
  event_router dut_u (.clk(clk), .nrst(nrst), .gen_in(gi), .gen_is_async(ga), .gen_write(gw), .user_write(uw),
    .software_event_trigger(sw), .channel_async(ca), .channel_sync(cs), .user_async_event(ua), .user_sync_event(us));
  // ==== helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    fail_count += int'(got !== exp);
    if (got !== exp) $display("[FAIL] %0t got %h exp %h", $time, got, exp);
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input gen_write_t g, input user_write_t u);
    @(negedge clk) {gw, uw} = {g, u};
    @(negedge clk) {gw, uw} = '0;
  endtask
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ==== scenarios
  task automatic t_route();
    wr('{1'b1, 3'h0, GEN_FIRST}, '{1'b1, 4'h0, 3'h1});
    wr('{1'b1, 3'h6, 6'h02}, '{1'b1, 4'h1, 3'h7});
    tk(2);
    @(negedge clk) fire = 1'b1;
    @(negedge clk) fire = 1'b0;
    tk(1);
    chk(8'({ca[0], cs[0], us[0], ua[0], us[1]}), 8'h1e);
    tk(1);
    chk(8'({ca[0], cs[0], us[0], ua[0], us[1]}), 8'h00);
    $display("route done");
  endtask
  task automatic t_async();
    int n;
    n = 0;
    wr('{1'b1, 3'h0, 6'h20}, '0);
    tk(3);
    @(negedge clk) pin = 1'b1;
    tk(1);
    chk(8'({ca[0], cs[0]}), 8'h02);
    while (cs[0] !== 1'b1 && n < 8)
    begin
      tk(1);
      n++;
    end
    chk(8'(n), 8'h02);
    @(negedge clk) pin = 1'b0;
    $display("async done");
  endtask
  task automatic t_swev();
    int k;
    k = 0;
    wr('{1'b1, 3'h0, GEN_NONE}, '0);
    tk(4);
    chk(8'({ca[0], cs[0]}), 8'h00);
    @(negedge clk) sw = 6'h01;
    repeat (4)
    begin
      tk(1);
      k += int'(ca[0] === 1'b1 && cs[0] === 1'b1);
      @(negedge clk) sw = 6'h00;
    end
    chk(8'(k), 8'h01);
    $display("swev done");
  endtask
  initial
  begin
    repeat (400) @(posedge clk);
    fail_count++;
    finish_test();
  end
  initial
  begin
    repeat (3) @(posedge clk);
    @(negedge clk) nrst = 1'b1;
    tk(3);
    t_route();
    t_async();
    t_swev();
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
